// ===== bench/ea_calc_asserts.sv
// Concurrent checks on the effective address stage
`timescale 1ns/1ps
module ea_calc_asserts
    import ea_calc_pkg::*;
(
    input wire logic       SYS_CLK_IN, // Clock
    input wire logic       RESET_IN,   // Reset
    input wire ea_req_type REQ_IN,     // Request
    input wire ea_res_type RES_OUT     // Result
);
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (RESET_IN);
    // Short views; each result answers the request one edge before
    wire ea_mode_type m = REQ_IN.mode;
    wire [1:0]        s = REQ_IN.size;
    wire [11:0]       d = REQ_IN.disp;
    wire [31:0]       g = REQ_IN.global_base_reg;
    wire [31:0]       z = REQ_IN.index_register_zero;
    wire [31:0]       n = REQ_IN.selected_general_register;
    wire [31:0]       p = REQ_IN.pc;
    wire [31:0]       r = RES_OUT.value;
    property p_idx; m == MODE_INDEXED_GBR |=> r == $past(g + z); endproperty
    a_idx: assert property (p_idx) else $error("bad idx");
    property p_rd4; m == MODE_REG_DISP4 |=> r == $past(n + ({28'h0, d[3:0]} << s)); endproperty
    a_rd4: assert property (p_rd4) else $error("bad rd4");
    property p_gd8; m == MODE_GBR_DISP8 |=> r == $past(g + ({24'h0, d[7:0]} << s)); endproperty
    a_gd8: assert property (p_gd8) else $error("bad gd8");
    property p_pcl; m == MODE_PC_DISP8 && s == SIZE_LONG |=>
        r == $past((p & 32'hFFFF_FFFC) + {d[7:0], 2'h0}); endproperty
    a_pcl: assert property (p_pcl) else $error("bad pcl");
    property p_br8; m == MODE_BRANCH_DISP8 |=>
        r == $past(p + {{23{d[7]}}, d[7:0], 1'b0}); endproperty
    a_br8: assert property (p_br8) else $error("bad br8");
    property p_br12; m == MODE_BRANCH_DISP12 |=>
        r == $past(p + {{19{d[11]}}, d, 1'b0}); endproperty
    a_br12: assert property (p_br12) else $error("bad br12");
    property p_pcr; m == MODE_PC_REG |=> r == $past(p + n); endproperty
    a_pcr: assert property (p_pcr) else $error("bad pcr");
    property p_trp; m == MODE_IMM_TRAP |=> r == $past({22'h0, d[7:0], 2'h0}); endproperty
    a_trp: assert property (p_trp) else $error("bad trp");
    property p_pcw; m == MODE_PC_DISP8 && s != SIZE_LONG |=>
        r == $past(p + {d[7:0], 1'h0}); endproperty
    a_pcw: assert property (p_pcw) else $error("bad pcw");
    property p_imz; m == MODE_IMM_ZERO |=> r == $past({24'h0, d[7:0]}); endproperty
    a_imz: assert property (p_imz) else $error("bad imz");
    property p_ims; m == MODE_IMM_SIGN |=> r == $past({{24{d[7]}}, d[7:0]}); endproperty
    a_ims: assert property (p_ims) else $error("bad ims");
endmodule
bind effective_address_calc ea_calc_asserts i_chk (.SYS_CLK_IN(SYS_CLK_IN), .RESET_IN(RESET_IN),
    .REQ_IN(REQ_IN), .RES_OUT(RES_OUT));

// ===== bench/ea_decoder_model.sv
// Decoder stand-in that launches requests
`timescale 1ns/1ps
module ea_decoder_model
    import ea_calc_pkg::*;
(
    input  wire logic       clk_in,  // Clock
    input  wire ea_req_type cmd_in,  // Bench fields
    output ea_req_type      req_out  // To the stage
);
    // Falling-edge launch keeps fields clear of the sampling edge
    initial req_out = '0;
    always @(negedge clk_in) begin
        req_out <= cmd_in;
    end
endmodule

// ===== bench/effective_address_calc_tb.sv
// Bench for the effective address stage
`timescale 1ns/1ps
module effective_address_calc_tb
    import ea_calc_pkg::*;
;
    logic       SYS_CLK_IN;
    logic       RESET_IN;
    ea_req_type cmd;
    ea_req_type REQ_IN;
    ea_res_type RES_OUT;
    int         n_fail = 0;
    int         total_checks = 0;
    ea_decoder_model i_src (.clk_in(SYS_CLK_IN), .cmd_in(cmd), .req_out(REQ_IN));
    effective_address_calc i_dut (.SYS_CLK_IN(SYS_CLK_IN), .RESET_IN(RESET_IN), .REQ_IN(REQ_IN),
        .RES_OUT(RES_OUT));
    // 125 MHz clock
    initial begin
        SYS_CLK_IN = 1'b0;
        forever #4 SYS_CLK_IN = ~SYS_CLK_IN;
    end
    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        total_checks++;
        if (seen !== want) begin
            n_fail++;
            $display("unexpected at %0t: %h not %h", $time, seen, want);
        end
    endtask
    // Two falling edges: model launch, then check after the rising-edge stage register
    task automatic run(input ea_mode_type m, input op_size_type s, input logic [11:0] d,
        input logic [31:0] e);
        {cmd.mode, cmd.size, cmd.disp} <= {m, s, d};
        repeat (2) @(negedge SYS_CLK_IN);
        check(RES_OUT, {1'b1, e});
    endtask
    // Base sums wrap past the top; upper field bits must be ignored
    task automatic t_base;
        run(MODE_INDEXED_GBR, SIZE_BYTE, 12'h000, 32'h10);
        for (int i = 0; i < 3; i++) begin
            run(MODE_GBR_DISP8, op_size_type'(i), 12'hFFF, 32'hFFFF_FFF0 + (32'hFF << i));
            run(MODE_REG_DISP4, op_size_type'(i), 12'hFFF, 32'h1234_5679 + (32'hF << i));
        end
        $display("base done");
    endtask
    // PC low bits set so the longword mask shows
    task automatic t_pc;
        run(MODE_PC_DISP8, SIZE_LONG, 12'hF81, 32'h1204);
        run(MODE_PC_DISP8, SIZE_WORD, 12'hF81, 32'h1105);
        run(MODE_PC_DISP8, SIZE_BYTE, 12'hF81, 32'h1105);
        run(MODE_BRANCH_DISP12, SIZE_WORD, 12'h7FF, 32'h2001);
        run(MODE_IMM_SIGN, SIZE_BYTE, 12'hF7F, 32'h7F);
        run(MODE_BRANCH_DISP8, SIZE_WORD, 12'hF80, 32'hF03);
        run(MODE_BRANCH_DISP12, SIZE_WORD, 12'h800, 32'h3);
        run(MODE_PC_REG, SIZE_LONG, 12'hFFF, 32'h1234_667C);
        run(MODE_IMM_ZERO, SIZE_BYTE, 12'hFF0, 32'hF0);
        run(MODE_IMM_SIGN, SIZE_BYTE, 12'h0F0, 32'hFFFF_FFF0);
        run(MODE_IMM_TRAP, SIZE_BYTE, 12'hFFF, 32'h3FC);
        $display("pc and imm done");
    endtask
    // Invalid request still computes; mid-run reset clears the result
    task automatic t_ctrl;
        cmd.valid <= 1'h0;
        {cmd.mode, cmd.size, cmd.disp} <= {MODE_PC_REG, SIZE_WORD, 12'h000};
        repeat (2) @(negedge SYS_CLK_IN);
        check(RES_OUT, {1'h0, 32'h1234_667C});
        cmd.valid <= 1'h1;
        RESET_IN = 1'h1;
        repeat (2) @(negedge SYS_CLK_IN);
        check(RES_OUT, 33'h0);
        RESET_IN = 1'h0;
        $display("valid and reset done");
    endtask
    task automatic wrap_up;
        $display("%0d checks, %0d failed", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Hang guard, far past the 60 or so cycles needed
    initial begin
        #5000;
        n_fail++;
        wrap_up();
    end
    // Reset, then the scenarios
    initial begin
        RESET_IN = 1'b1;
        cmd = '{1'b1, MODE_INDEXED_GBR, SIZE_BYTE, 12'h0, 32'hFFFF_FFF0, 32'h20, 32'h1234_5679,
            32'h1003};
        repeat (20) @(negedge SYS_CLK_IN);
        check(RES_OUT, 33'h0);
        RESET_IN = 1'b0;
        t_base();
        t_ctrl();
        t_pc();
        wrap_up();
    end
endmodule

// ===== hw/disp_extend.sv
// Extends and scales a displacement or immediate field
`timescale 1ns/1ps
`include "ea_calc_map.svh"
module disp_extend
    import ea_calc_pkg::*;
(
    input  wire logic [11:0] disp_in,   // Raw field
    input  wire logic [3:0]  width_in,  // Field width: 4, 8 or 12
    input  wire logic        sign_in,   // Sign-extend when high
    input  wire logic [1:0]  shift_in,  // Scale as left shift
    output logic      [31:0] value_out  // Extended, scaled value
);
    logic [31:0] ext;

    // Mask to field width, then optionally replicate the top bit
    always_comb begin
        ext = `EA_ZERO;
        unique case (width_in)
            `EA_FIELD_DISP4: begin
                ext = {{(`EA_WIDTH - `EA_DISP4_MSB - 1){sign_in & disp_in[`EA_DISP4_MSB]}},
                       disp_in[`EA_DISP4_MSB:0]};
            end
            `EA_FIELD_DISP8: begin
                ext = {{(`EA_WIDTH - `EA_DISP8_MSB - 1){sign_in & disp_in[`EA_DISP8_MSB]}},
                       disp_in[`EA_DISP8_MSB:0]};
            end
            default: begin
                ext = {{(`EA_WIDTH - `EA_DISP12_MSB - 1){sign_in & disp_in[`EA_DISP12_MSB]}},
                       disp_in[`EA_DISP12_MSB:0]};
            end
        endcase
        value_out = ext << shift_in;
    end
endmodule

// ===== hw/ea_adder.sv
// Wrapping 32-bit address adder
`timescale 1ns/1ps
module ea_adder
    import ea_calc_pkg::*;
(
    input  wire logic [31:0] a_in,   // First addend
    input  wire logic [31:0] b_in,   // Second addend
    output logic      [31:0] sum_out // Sum modulo 2^32
);
    logic [32:0] full;

    // Carry out is dropped on purpose, addresses wrap
    always_comb begin
        full    = {1'h0, a_in} + {1'h0, b_in};
        sum_out = full[31:0]; // see RULE12
    end
endmodule

// ===== hw/ea_calc_map.svh
// Encodings and constants for the effective address datapath
`ifndef EA_CALC_MAP_SVH
`define EA_CALC_MAP_SVH
`define EA_WIDTH        32
`define EA_ZERO         32'h0000_0000
`define EA_LONG_MASK    32'hFFFF_FFFC
`define EA_SHIFT_BYTE   2'h0
`define EA_SHIFT_WORD   2'h1
`define EA_SHIFT_LONG   2'h2
`define EA_SHIFT_TRAP   2'h2
`define EA_SHIFT_BRANCH 2'h1
`define EA_FIELD_DISP4  4'h4
`define EA_FIELD_DISP8  4'h8
`define EA_FIELD_DISP12 4'hC
`define EA_DISP4_MSB    3
`define EA_DISP8_MSB    7
`define EA_DISP12_MSB   11
`endif

// ===== hw/ea_calc_pkg.sv
// Types shared by the effective address datapath
package ea_calc_pkg;
    // Addressing modes and immediate kinds selected by the decoder
    typedef enum logic [3:0] {
        MODE_INDEXED_GBR,
        MODE_REG_DISP4,
        MODE_GBR_DISP8,
        MODE_PC_DISP8,
        MODE_BRANCH_DISP8,
        MODE_BRANCH_DISP12,
        MODE_PC_REG,
        MODE_IMM_ZERO,
        MODE_IMM_SIGN,
        MODE_IMM_TRAP
    } ea_mode_type;

    typedef enum logic [1:0] {
        SIZE_BYTE,
        SIZE_WORD,
        SIZE_LONG
    } op_size_type;

    // One request from the decoder and register file
    typedef struct packed {
        logic        valid;
        ea_mode_type mode;
        op_size_type size;
        logic [11:0] disp;
        logic [31:0] global_base_reg;
        logic [31:0] index_register_zero;
        logic [31:0] selected_general_register;
        logic [31:0] pc;
    } ea_req_type;

    // One result towards load/store and branch logic
    typedef struct packed {
        logic        valid;
        logic [31:0] value;
    } ea_res_type;

    typedef struct packed {
        ea_res_type res;
    } ea_state_type;
endpackage

// ===== hw/effective_address_calc.sv
// Effective address and immediate forming stage
// Functional notes
// RULE1: Indexed global base: address is global base plus register zero.
// RULE2: Register displacement: zero-extend 4-bit field, scale 1/2/4, add register.
// RULE3: PC data access: zero-extend 8-bit field, scale 2 or 4, add PC.
// RULE4: PC longword access clears PC's two low bits first.
// RULE5: Short branch: sign-extend 8-bit field, double, add PC.
// RULE6: Long branch: sign-extend 12-bit field, double, add PC.
// RULE7: Register PC-relative: PC plus register, no extension or scaling.
// RULE8: Test, AND, OR, XOR immediates are zero-extended 8-bit values.
// RULE9: Move, add, compare-equal immediates are sign-extended 8-bit values.
// RULE10: Trap immediate zero-extended and multiplied by four.
// RULE11: Global base displacement: zero-extend 8-bit, scale 1/2/4, add base.
// RULE12: All additions are 32-bit and wrap, carry discarded.
`timescale 1ns/1ps
`include "ea_calc_map.svh"
module effective_address_calc
    import ea_calc_pkg::*;
(
    input  wire logic       SYS_CLK_IN, // Core clock, 125 MHz
    input  wire logic       RESET_IN,   // Synchronous reset, active high
    input  wire ea_req_type REQ_IN,     // Decoded fields and operands
    output ea_res_type      RES_OUT     // Registered result, one cycle later
);
    ea_state_type state;
    ea_state_type next_state;
    logic [3:0]   ext_width;
    logic         ext_sign;
    logic [1:0]   ext_shift;
    logic [31:0]  ext_value;
    logic [31:0]  add_a;
    logic [31:0]  add_b;
    logic [31:0]  add_sum;
    logic         use_adder;

    // Operand size to scale shift; shared by the two register-base modes
    function automatic logic [1:0] size_shift(input op_size_type size);
        unique case (size)
            SIZE_BYTE: size_shift = `EA_SHIFT_BYTE;
            SIZE_WORD: size_shift = `EA_SHIFT_WORD;
            SIZE_LONG: size_shift = `EA_SHIFT_LONG;
            default:   size_shift = `EA_SHIFT_BYTE;
        endcase
    endfunction

    // Extender field width per mode; lanes that ignore it keep 8 bits
    function automatic logic [3:0] field_width(input ea_mode_type mode);
        unique case (mode)
            MODE_INDEXED_GBR: begin
                field_width = `EA_FIELD_DISP8;
            end
            MODE_REG_DISP4: begin
                field_width = `EA_FIELD_DISP4; // see RULE2
            end
            MODE_GBR_DISP8: begin
                field_width = `EA_FIELD_DISP8; // see RULE11
            end
            MODE_PC_DISP8: begin
                field_width = `EA_FIELD_DISP8; // see RULE3
            end
            MODE_BRANCH_DISP8: begin
                field_width = `EA_FIELD_DISP8; // see RULE5
            end
            MODE_BRANCH_DISP12: begin
                field_width = `EA_FIELD_DISP12; // see RULE6
            end
            MODE_PC_REG: begin
                field_width = `EA_FIELD_DISP8;
            end
            MODE_IMM_ZERO: begin
                field_width = `EA_FIELD_DISP8; // see RULE8
            end
            MODE_IMM_SIGN: begin
                field_width = `EA_FIELD_DISP8; // see RULE9
            end
            MODE_IMM_TRAP: begin
                field_width = `EA_FIELD_DISP8; // see RULE10
            end
            default: begin
                field_width = `EA_FIELD_DISP8;
            end
        endcase
    endfunction

    // Only branches and arithmetic immediates carry a sign
    function automatic logic field_sign(input ea_mode_type mode);
        unique case (mode)
            MODE_INDEXED_GBR: begin
                field_sign = 1'h0;
            end
            MODE_REG_DISP4: begin
                field_sign = 1'h0; // see RULE2
            end
            MODE_GBR_DISP8: begin
                field_sign = 1'h0; // see RULE11
            end
            MODE_PC_DISP8: begin
                field_sign = 1'h0; // see RULE3
            end
            MODE_BRANCH_DISP8: begin
                field_sign = 1'h1; // see RULE5
            end
            MODE_BRANCH_DISP12: begin
                field_sign = 1'h1; // see RULE6
            end
            MODE_PC_REG: begin
                field_sign = 1'h0;
            end
            MODE_IMM_ZERO: begin
                field_sign = 1'h0; // see RULE8
            end
            MODE_IMM_SIGN: begin
                field_sign = 1'h1; // see RULE9
            end
            MODE_IMM_TRAP: begin
                field_sign = 1'h0; // see RULE10
            end
            default: begin
                field_sign = 1'h0;
            end
        endcase
    endfunction

    // Scale as a left shift; byte size on a PC data access acts as word
    function automatic logic [1:0] field_shift(input ea_mode_type mode,
                                               input op_size_type size);
        unique case (mode)
            MODE_INDEXED_GBR: begin
                field_shift = `EA_SHIFT_BYTE;
            end
            MODE_REG_DISP4: begin
                field_shift = size_shift(size); // see RULE2
            end
            MODE_GBR_DISP8: begin
                field_shift = size_shift(size); // see RULE11
            end
            MODE_PC_DISP8: begin
                if (size == SIZE_LONG) begin
                    field_shift = `EA_SHIFT_LONG; // see RULE3
                end else begin
                    field_shift = `EA_SHIFT_WORD; // see RULE3
                end
            end
            MODE_BRANCH_DISP8: begin
                field_shift = `EA_SHIFT_BRANCH; // see RULE5
            end
            MODE_BRANCH_DISP12: begin
                field_shift = `EA_SHIFT_BRANCH; // see RULE6
            end
            MODE_PC_REG: begin
                field_shift = `EA_SHIFT_BYTE;
            end
            MODE_IMM_ZERO: begin
                field_shift = `EA_SHIFT_BYTE; // see RULE8
            end
            MODE_IMM_SIGN: begin
                field_shift = `EA_SHIFT_BYTE; // see RULE9
            end
            MODE_IMM_TRAP: begin
                field_shift = `EA_SHIFT_TRAP; // see RULE10
            end
            default: begin
                field_shift = `EA_SHIFT_BYTE;
            end
        endcase
    endfunction

    // First addend; unknown codes fall back to the PC
    function automatic logic [31:0] base_operand(input ea_req_type req);
        unique case (req.mode)
            MODE_INDEXED_GBR: begin
                base_operand = req.global_base_reg; // see RULE1
            end
            MODE_REG_DISP4: begin
                base_operand = req.selected_general_register; // see RULE2
            end
            MODE_GBR_DISP8: begin
                base_operand = req.global_base_reg; // see RULE11
            end
            MODE_PC_DISP8: begin
                if (req.size == SIZE_LONG) begin
                    base_operand = req.pc & `EA_LONG_MASK; // see RULE4
                end else begin
                    base_operand = req.pc; // see RULE3
                end
            end
            MODE_BRANCH_DISP8: begin
                base_operand = req.pc; // see RULE5
            end
            MODE_BRANCH_DISP12: begin
                base_operand = req.pc; // see RULE6
            end
            MODE_PC_REG: begin
                base_operand = req.pc; // see RULE7
            end
            MODE_IMM_ZERO: begin
                base_operand = req.pc;
            end
            MODE_IMM_SIGN: begin
                base_operand = req.pc;
            end
            MODE_IMM_TRAP: begin
                base_operand = req.pc;
            end
            default: begin
                base_operand = req.pc;
            end
        endcase
    endfunction

    // Second addend: a register for the two register sums, else the field
    function automatic logic [31:0] addend_operand(input ea_req_type  req,
                                                   input logic [31:0] ext);
        unique case (req.mode)
            MODE_INDEXED_GBR: begin
                addend_operand = req.index_register_zero; // see RULE1
            end
            MODE_REG_DISP4: begin
                addend_operand = ext; // see RULE2
            end
            MODE_GBR_DISP8: begin
                addend_operand = ext; // see RULE11
            end
            MODE_PC_DISP8: begin
                addend_operand = ext; // see RULE3
            end
            MODE_BRANCH_DISP8: begin
                addend_operand = ext; // see RULE5
            end
            MODE_BRANCH_DISP12: begin
                addend_operand = ext; // see RULE6
            end
            MODE_PC_REG: begin
                addend_operand = req.selected_general_register; // see RULE7
            end
            MODE_IMM_ZERO: begin
                addend_operand = ext;
            end
            MODE_IMM_SIGN: begin
                addend_operand = ext;
            end
            MODE_IMM_TRAP: begin
                addend_operand = ext;
            end
            default: begin
                addend_operand = ext;
            end
        endcase
    endfunction

    // Immediates bypass the adder and go out as extended
    function automatic logic adder_used(input ea_mode_type mode);
        unique case (mode)
            MODE_INDEXED_GBR:   adder_used = 1'h1;
            MODE_REG_DISP4:     adder_used = 1'h1;
            MODE_GBR_DISP8:     adder_used = 1'h1;
            MODE_PC_DISP8:      adder_used = 1'h1;
            MODE_BRANCH_DISP8:  adder_used = 1'h1;
            MODE_BRANCH_DISP12: adder_used = 1'h1;
            MODE_PC_REG:        adder_used = 1'h1;
            MODE_IMM_ZERO:      adder_used = 1'h0; // see RULE8
            MODE_IMM_SIGN:      adder_used = 1'h0; // see RULE9
            MODE_IMM_TRAP:      adder_used = 1'h0; // see RULE10
            default:            adder_used = 1'h1;
        endcase
    endfunction

    // Extender controls; kept apart from the adder select to avoid a loop
    always_comb begin
        ext_width = field_width(REQ_IN.mode);
        ext_sign  = field_sign(REQ_IN.mode);
        ext_shift = field_shift(REQ_IN.mode, REQ_IN.size);
    end

    // Adder operands and result select
    always_comb begin
        add_a     = base_operand(REQ_IN);
        add_b     = addend_operand(REQ_IN, ext_value);
        use_adder = adder_used(REQ_IN.mode);
    end

    disp_extend u_extend (
        .disp_in  (REQ_IN.disp),
        .width_in (ext_width),
        .sign_in  (ext_sign),
        .shift_in (ext_shift),
        .value_out(ext_value)
    );

    ea_adder u_adder (
        .a_in   (add_a),
        .b_in   (add_b),
        .sum_out(add_sum)
    );

    // Next state: result sampled once per cycle, no stall
    always_comb begin
        next_state           = state;
        next_state.res.valid = REQ_IN.valid;
        next_state.res.value = use_adder ? add_sum : ext_value;
    end

    // Single register stage keeps the output straight from a flop
    always_ff @(posedge SYS_CLK_IN) begin
        if (RESET_IN) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign RES_OUT = state.res;
endmodule
